//--- src/drive_status_pkg.sv
package drive_status_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CODE_W       = 3;
  localparam int unsigned SPEED_W      = 14;
  localparam int unsigned PIN_SEL_W    = 3;
  localparam int unsigned NUM_PINS     = 6;
  localparam int unsigned NUM_SIGS     = 6;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS       = 12'h000;
  localparam logic [ADDR_W-1:0] ROT_LEVEL_OFS  = 12'h004;
  localparam logic [ADDR_W-1:0] LIN_LEVEL_OFS  = 12'h008;
  localparam logic [ADDR_W-1:0] ALLOC_A_OFS    = 12'h00C;
  localparam logic [ADDR_W-1:0] ALLOC_B_OFS    = 12'h010;
  localparam logic [ADDR_W-1:0] CODE_ALLOC_OFS = 12'h014;
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 12'h018;

  // control register fields
  localparam int unsigned CTRL_WARN_SEL_BIT = 0;
  localparam int unsigned CTRL_LINEAR_BIT   = 1;
  localparam int unsigned CTRL_ABS_ENC_BIT  = 2;
  localparam int unsigned CTRL_NO_POL_BIT   = 3;
  localparam int unsigned CTRL_RESTART_BIT  = 4;

  // allocation fields, pin select 0 means not used, 1..6 pick a pin
  localparam int unsigned ALLOC_MOTION_LSB = 0;
  localparam int unsigned ALLOC_READY_LSB  = 4;
  localparam int unsigned ALLOC_WARN_LSB   = 0;
  localparam int unsigned ALLOC_CODE0_LSB  = 0;
  localparam int unsigned ALLOC_CODE1_LSB  = 4;
  localparam int unsigned ALLOC_CODE2_LSB  = 8;

  // status register fields
  localparam int unsigned STAT_CODE_LSB    = 0;
  localparam int unsigned STAT_WARN_BIT    = 3;
  localparam int unsigned STAT_MOTION_BIT  = 4;
  localparam int unsigned STAT_READY_BIT   = 5;
  localparam int unsigned STAT_WSEL_BIT    = 6;
  localparam int unsigned STAT_POL_RUN_BIT = 7;
  localparam int unsigned STAT_POL_OK_BIT  = 8;

  // detection level range and default
  localparam logic [SPEED_W-1:0] LEVEL_MIN     = 14'h0001;
  localparam logic [SPEED_W-1:0] LEVEL_MAX     = 14'h2710;
  localparam logic [SPEED_W-1:0] LEVEL_DEFAULT = 14'h0014;

  // default pin allocations
  localparam logic [PIN_SEL_W-1:0] PIN_NONE        = 3'h0;
  localparam logic [PIN_SEL_W-1:0] MOTION_PIN_DEF  = 3'h2;
  localparam logic [PIN_SEL_W-1:0] READY_PIN_DEF   = 3'h3;
  localparam logic [PIN_SEL_W-1:0] CODE0_PIN_DEF   = 3'h4;
  localparam logic [PIN_SEL_W-1:0] CODE1_PIN_DEF   = 3'h5;
  localparam logic [PIN_SEL_W-1:0] CODE2_PIN_DEF   = 3'h6;

  localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;

  typedef struct packed {
    logic               main_power_on;
    logic               hw_base_block;
    logic               alarm_active;
    logic [CODE_W-1:0]  alarm_code;
    logic               warning_active;
    logic [CODE_W-1:0]  warning_code;
    logic               abs_data_request;
    logic               abs_transfer_done;
    logic               polarity_done;
    logic               servo_on;
    logic [SPEED_W-1:0] speed;
  } drive_in_t;

  typedef struct packed {
    logic warn_sel;
    logic linear;
    logic abs_enc;
    logic no_pol_sensor;
  } drive_cfg_t;

  typedef enum logic [2:0] {
    POL_FIRST   = 3'b001,
    POL_RUNNING = 3'b010,
    POL_DONE    = 3'b100
  } pol_state_t;

endpackage

//--- src/pin_or_mapper.sv
module pin_or_mapper
  import drive_status_pkg::*;
(
  input  wire logic [NUM_SIGS-1:0]           sig_in,
  input  wire logic [NUM_SIGS*PIN_SEL_W-1:0] sel_in,
  output logic      [NUM_PINS-1:0]           pin_out
);

  // pins are numbered 1..NUM_PINS, select 0 leaves a signal unconnected
  genvar p;
  genvar s;
  generate
    for (p = 0; p < NUM_PINS; p = p + 1) begin : g_pin
      wire [NUM_SIGS-1:0] hit;
      for (s = 0; s < NUM_SIGS; s = s + 1) begin : g_sig
        assign hit[s] = sig_in[s] && (sel_in[s*PIN_SEL_W +: PIN_SEL_W] == PIN_SEL_W'(p + 1));
      end
      assign pin_out[p] = |hit;
    end
  endgenerate

endmodule

//--- src/drive_status_outputs.sv
// How it works
// - three code lines report active fault
// - warning flag closed while warning exists
// - select zero: alarm codes only
// - select one: warning and alarm codes
// - alarm code wins over warning code
// - rotary: motion when speed at rotary level
// - linear: motion when speed at linear level
// - motion inactive below applicable level
// - level 1 to 10000, default 20
// - ready needs power, no base block, no alarm
// - ready active when enable can be accepted
// - absolute encoder: ready low while request low
// - absolute encoder: wait for position transfer
// - no polarity sensor: detection must be done
// - first enable skips check, starts detection
// - shared pin drives or of its signals
module drive_status_outputs
  import drive_status_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire drive_in_t         drive_in,
  output logic                   fault_code_bit0,
  output logic                   fault_code_bit1,
  output logic                   fault_code_bit2,
  output logic                   warning_flag,
  output logic                   motion_detected_n,
  output logic                   servo_ready,
  output logic                   polarity_detect_start,
  output logic      [NUM_PINS-1:0] out_pin_closed
);

  // range check shared by both level registers
  function automatic logic level_ok(input logic [DATA_W-1:0] v);
    level_ok = (v >= DATA_W'(LEVEL_MIN)) && (v <= DATA_W'(LEVEL_MAX));
  endfunction

  // registers
  drive_cfg_t                cfg_q;
  drive_cfg_t                cfg_d;
  logic                      warn_sel_act_q;
  logic                      warn_sel_act_d;
  logic [SPEED_W-1:0]        rot_level_q;
  logic [SPEED_W-1:0]        rot_level_d;
  logic [SPEED_W-1:0]        lin_level_q;
  logic [SPEED_W-1:0]        lin_level_d;
  logic [PIN_SEL_W-1:0]      motion_pin_q;
  logic [PIN_SEL_W-1:0]      ready_pin_q;
  logic [PIN_SEL_W-1:0]      warn_pin_q;
  logic [PIN_SEL_W-1:0]      code0_pin_q;
  logic [PIN_SEL_W-1:0]      code1_pin_q;
  logic [PIN_SEL_W-1:0]      code2_pin_q;
  logic                      boot_q;
  pol_state_t                pol_q;
  pol_state_t                pol_d;
  logic [CODE_W-1:0]         code_q;
  logic [CODE_W-1:0]         code_d;
  logic                      warn_q;
  logic                      motion_n_q;
  logic                      ready_q;
  logic                      ready_d;
  logic                      pol_start_q;
  logic                      pol_start_d;
  logic [NUM_PINS-1:0]       pins_q;
  logic [NUM_PINS-1:0]       pins_d;
  logic                      pready_q;
  logic                      pready_d;
  logic                      pslverr_q;
  logic                      pslverr_d;
  logic [DATA_W-1:0]         prdata_q;
  logic [DATA_W-1:0]         prdata_d;

  // bus decode: one wait state, so every bus output is a flop
  wire access   = psel && penable;
  wire wr_en    = access && pready_q && pwrite;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_rot  = (paddr == ROT_LEVEL_OFS);
  wire hit_lin  = (paddr == LIN_LEVEL_OFS);
  wire hit_a    = (paddr == ALLOC_A_OFS);
  wire hit_b    = (paddr == ALLOC_B_OFS);
  wire hit_code = (paddr == CODE_ALLOC_OFS);
  wire hit_stat = (paddr == STATUS_OFS);
  wire mapped   = hit_ctrl || hit_rot || hit_lin || hit_a || hit_b || hit_code || hit_stat;
  wire ro_write = pwrite && hit_stat;

  wire wr_ctrl  = wr_en && hit_ctrl;
  wire wr_rot   = wr_en && hit_rot;
  wire wr_lin   = wr_en && hit_lin;
  wire wr_a     = wr_en && hit_a;
  wire wr_b     = wr_en && hit_b;
  wire wr_code  = wr_en && hit_code;
  // restart strobe reloads the running code selection
  wire restart  = wr_ctrl && pwdata[CTRL_RESTART_BIT];

  // status is read only, a write there is answered with an error
  assign pready_d  = access && !pready_q;
  assign pslverr_d = pready_d && (!mapped || ro_write);

  assign cfg_d = wr_ctrl ? '{warn_sel:      pwdata[CTRL_WARN_SEL_BIT],
                             linear:        pwdata[CTRL_LINEAR_BIT],
                             abs_enc:       pwdata[CTRL_ABS_ENC_BIT],
                             no_pol_sensor: pwdata[CTRL_NO_POL_BIT]} : cfg_q;

  // staged copy only reaches the code lines at restart or reset
  assign warn_sel_act_d = (restart || boot_q) ? (wr_ctrl ? pwdata[CTRL_WARN_SEL_BIT] : cfg_q.warn_sel)
                                              : warn_sel_act_q;

  // out of range writes are dropped, old level stays
  assign rot_level_d = (wr_rot && level_ok(pwdata)) ? pwdata[SPEED_W-1:0] : rot_level_q;
  assign lin_level_d = (wr_lin && level_ok(pwdata)) ? pwdata[SPEED_W-1:0] : lin_level_q;

  // fault code selection
  wire show_warn = warn_sel_act_q && drive_in.warning_active;
  assign code_d  = drive_in.alarm_active ? drive_in.alarm_code
                 : show_warn             ? drive_in.warning_code
                 :                         CODE_NONE;

  // motion detection, compare is immediate on the active level
  wire [SPEED_W-1:0] level_sel = cfg_q.linear ? lin_level_q : rot_level_q;
  wire               motion_d  = (drive_in.speed >= level_sel);

  // polarity detection sequence
  wire pol_needed = cfg_q.no_pol_sensor;
  always_comb begin
    pol_d       = pol_q;
    pol_start_d = 1'b0;
    case (pol_q)
      POL_FIRST: begin
        if (pol_needed && drive_in.servo_on) begin
          pol_d       = POL_RUNNING;
          pol_start_d = 1'b1;
        end
      end
      POL_RUNNING: begin
        if (drive_in.polarity_done) begin
          pol_d = POL_DONE;
        end
      end
      // done is left only by reset, which also rearms the first-enable skip
      POL_DONE: begin
        pol_d = POL_DONE;
      end
      default: begin
        pol_d = POL_FIRST;
      end
    endcase
  end

  // before first enable the polarity term is not counted
  wire pol_ok  = !pol_needed || (pol_q == POL_FIRST) || (pol_q == POL_DONE) ||
                 drive_in.polarity_done;
  wire base_ok = drive_in.main_power_on && !drive_in.hw_base_block && !drive_in.alarm_active;
  // a slow host may raise the request late, ready simply waits for it
  wire abs_ok  = !cfg_q.abs_enc || (drive_in.abs_data_request && drive_in.abs_transfer_done);
  assign ready_d = base_ok && abs_ok && pol_ok;

  // pin mapping, warning stays off every pin until allocated
  wire [NUM_SIGS-1:0]           map_sig = {code_d[2], code_d[1], code_d[0],
                                           drive_in.warning_active, ready_d, motion_d};
  wire [NUM_SIGS*PIN_SEL_W-1:0] map_sel = {code2_pin_q, code1_pin_q, code0_pin_q,
                                           warn_pin_q, ready_pin_q, motion_pin_q};

  // pins take next-state values so they line up with the status flops
  pin_or_mapper u_map (
    .sig_in  (map_sig),
    .sel_in  (map_sel),
    .pin_out (pins_d)
  );

  // read mux
  wire [DATA_W-1:0] rd_ctrl = DATA_W'({cfg_q.no_pol_sensor, cfg_q.abs_enc, cfg_q.linear, cfg_q.warn_sel});
  wire [DATA_W-1:0] rd_a    = (DATA_W'(motion_pin_q) << ALLOC_MOTION_LSB) |
                              (DATA_W'(ready_pin_q) << ALLOC_READY_LSB);
  wire [DATA_W-1:0] rd_b    = DATA_W'(warn_pin_q) << ALLOC_WARN_LSB;
  wire [DATA_W-1:0] rd_code = (DATA_W'(code0_pin_q) << ALLOC_CODE0_LSB) |
                              (DATA_W'(code1_pin_q) << ALLOC_CODE1_LSB) |
                              (DATA_W'(code2_pin_q) << ALLOC_CODE2_LSB);
  wire [DATA_W-1:0] rd_stat = (DATA_W'(code_q) << STAT_CODE_LSB) |
                              (DATA_W'(warn_q) << STAT_WARN_BIT) |
                              (DATA_W'(!motion_n_q) << STAT_MOTION_BIT) |
                              (DATA_W'(ready_q) << STAT_READY_BIT) |
                              (DATA_W'(warn_sel_act_q) << STAT_WSEL_BIT) |
                              (DATA_W'(pol_q == POL_RUNNING) << STAT_POL_RUN_BIT) |
                              (DATA_W'(pol_q == POL_DONE) << STAT_POL_OK_BIT);
  wire [DATA_W-1:0] rd_mux  = hit_ctrl ? rd_ctrl
                            : hit_rot  ? DATA_W'(rot_level_q)
                            : hit_lin  ? DATA_W'(lin_level_q)
                            : hit_a    ? rd_a
                            : hit_b    ? rd_b
                            : hit_code ? rd_code
                            : hit_stat ? rd_stat
                            :            '0;
  assign prdata_d = (pready_d && !pwrite) ? rd_mux : prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q          <= '0;
      warn_sel_act_q <= 1'b0;
      boot_q         <= 1'b1;
      rot_level_q    <= LEVEL_DEFAULT;
      lin_level_q    <= LEVEL_DEFAULT;
    end else begin
      cfg_q          <= cfg_d;
      warn_sel_act_q <= warn_sel_act_d;
      boot_q         <= 1'b0;
      rot_level_q    <= rot_level_d;
      lin_level_q    <= lin_level_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_pin_q <= MOTION_PIN_DEF;
      ready_pin_q  <= READY_PIN_DEF;
    end else if (wr_a) begin
      motion_pin_q <= pwdata[ALLOC_MOTION_LSB +: PIN_SEL_W];
      ready_pin_q  <= pwdata[ALLOC_READY_LSB +: PIN_SEL_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_pin_q <= PIN_NONE;
    end else if (wr_b) begin
      warn_pin_q <= pwdata[ALLOC_WARN_LSB +: PIN_SEL_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code0_pin_q <= CODE0_PIN_DEF;
      code1_pin_q <= CODE1_PIN_DEF;
      code2_pin_q <= CODE2_PIN_DEF;
    end else if (wr_code) begin
      code0_pin_q <= pwdata[ALLOC_CODE0_LSB +: PIN_SEL_W];
      code1_pin_q <= pwdata[ALLOC_CODE1_LSB +: PIN_SEL_W];
      code2_pin_q <= pwdata[ALLOC_CODE2_LSB +: PIN_SEL_W];
    end
  end

  // status flops, one cycle behind the inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q       <= POL_FIRST;
      pol_start_q <= 1'b0;
      code_q      <= CODE_NONE;
      warn_q      <= 1'b0;
      motion_n_q  <= 1'b1;
      ready_q     <= 1'b0;
      pins_q      <= '0;
    end else begin
      pol_q       <= pol_d;
      pol_start_q <= pol_start_d;
      code_q      <= code_d;
      warn_q      <= drive_in.warning_active;
      motion_n_q  <= !motion_d;
      ready_q     <= ready_d;
      pins_q      <= pins_d;
    end
  end

  // motion flag is flopped active low, no gate sits after the flop
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign fault_code_bit0       = code_q[0];
  assign fault_code_bit1       = code_q[1];
  assign fault_code_bit2       = code_q[2];
  assign warning_flag          = warn_q;
  assign motion_detected_n     = motion_n_q;
  assign servo_ready           = ready_q;
  assign polarity_detect_start = pol_start_q;
  assign out_pin_closed        = pins_q;

endmodule

//--- verif/status_chk.sv
module status_chk
  import drive_status_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire drive_in_t         drive_in,
  input wire logic              fault_code_bit0,
  input wire logic              fault_code_bit1,
  input wire logic              fault_code_bit2,
  input wire logic              warning_flag,
  input wire logic              motion_detected_n,
  input wire logic              servo_ready,
  input wire logic              polarity_detect_start,
  input wire logic [NUM_PINS-1:0] out_pin_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [CODE_W-1:0] code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
  wire              base_cond = drive_in.main_power_on && !drive_in.hw_base_block && !drive_in.alarm_active;

  a_alarm_code_wins: assert property (drive_in.alarm_active |=> code == $past(drive_in.alarm_code))
    else $error("alarm code not shown");
  a_quiet_no_code: assert property (!drive_in.alarm_active && !drive_in.warning_active |=> code == CODE_NONE)
    else $error("code shown without cause");
  a_warn_flag_track: assert property (1'b1 |=> warning_flag == $past(drive_in.warning_active))
    else $error("warning flag wrong");
  a_ready_has_cause: assert property (servo_ready |-> $past(base_cond))
    else $error("ready without its conditions");
  a_no_power_ready: assert property (!drive_in.main_power_on |=> !servo_ready)
    else $error("ready with power off");
  a_motion_at_max: assert property (drive_in.speed >= LEVEL_MAX |=> !motion_detected_n)
    else $error("motion missed at top speed");
  a_motion_at_zero: assert property (drive_in.speed == 14'h0000 |=> motion_detected_n)
    else $error("motion flagged at standstill");
  a_pol_start_pulse: assert property ($rose(polarity_detect_start) |=> !polarity_detect_start)
    else $error("detection start not a pulse");

  cover property (servo_ready ##1 !servo_ready);
  cover property (polarity_detect_start);
  cover property (!motion_detected_n);
endmodule

bind drive_status_outputs status_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .drive_in, .fault_code_bit0, .fault_code_bit1, .fault_code_bit2, .warning_flag,
  .motion_detected_n, .servo_ready, .polarity_detect_start, .out_pin_closed);

//--- verif/host_model.sv
module host_model
  import drive_status_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              want_abs,
  input  wire logic [CODE_W-1:0] code_in,
  output logic                   abs_req,
  output logic      [CODE_W-1:0] shown_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // request raised a cycle late, as a slow host would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abs_req    <= 1'b0;
      shown_code <= CODE_NONE;
    end else begin
      abs_req    <= want_abs;
      shown_code <= code_in;
    end
  end
endmodule

//--- verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drive_status_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, want_abs, wf, mn, sr, ps, abs_req;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [NUM_PINS-1:0] pins;
  wire  [CODE_W-1:0] code;
  logic [CODE_W-1:0] shown;
  drive_in_t din, dut_in;
  int fails, checks, cyc;

  always_comb begin
    dut_in = din;
    dut_in.abs_data_request = abs_req;
  end

  drive_status_outputs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_in(dut_in),
    .fault_code_bit0(code[0]), .fault_code_bit1(code[1]), .fault_code_bit2(code[2]), .warning_flag(wf),
    .motion_detected_n(mn), .servo_ready(sr), .polarity_detect_start(ps), .out_pin_closed(pins));
  host_model i_host (.pclk(pclk), .presetn(presetn), .want_abs(want_abs), .code_in(code), .abs_req(abs_req),
    .shown_code(shown));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task wt;
    @(posedge pclk);
    #1;
  endtask

  // waits on pready, never on a fixed count
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task sp(input logic [SPEED_W-1:0] s, input logic e);
    @(posedge pclk) din.speed <= s;
    wt;
    chk("motion_n", {31'h0, e}, {31'h0, mn});
  endtask

  task t_regs;
    apb(1'b0, ROT_LEVEL_OFS, 32'h0);
    chk("rot_level", 32'h14, rd);
    apb(1'b0, ALLOC_A_OFS, 32'h0);
    chk("alloc_a", 32'h32, rd);
    apb(1'b0, CODE_ALLOC_OFS, 32'h0);
    chk("code_alloc", 32'h654, rd);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, ROT_LEVEL_OFS, 32'h0);
    apb(1'b1, ROT_LEVEL_OFS, 32'h2711);
    apb(1'b0, ROT_LEVEL_OFS, 32'h0);
    chk("level_range", 32'h14, rd);
  endtask

  task t_codes;
    @(posedge pclk) din.warning_active <= 1'b1;
    din.warning_code <= 3'h3;
    wt;
    chk("warn_flag", 32'h1, {31'h0, wf});
    chk("sel_zero", 32'h0, {29'h0, code});
    apb(1'b1, CTRL_OFS, 32'h1);
    wt;
    wt;
    chk("staged", 32'h0, {29'h0, code});
    apb(1'b1, CTRL_OFS, 32'h11);
    wt;
    wt;
    chk("sel_one", 32'h3, {29'h0, code});
    chk("host_sees", 32'h3, {29'h0, shown});
    for (int i = 1; i < 8; i++) begin
      @(posedge pclk) din.alarm_active <= 1'b1;
      din.alarm_code <= i[2:0];
      wt;
      chk("alarm_wins", i, {29'h0, code});
      chk("ready_alarm", 32'h0, {31'h0, sr});
    end
    @(posedge pclk) din.alarm_active <= 1'b0;
    din.warning_code <= 3'h0;
    wt;
    chk("code_clear", 32'h0, {29'h0, code});
  endtask

  task t_motion;
    apb(1'b1, ROT_LEVEL_OFS, 32'h64);
    sp(14'h63, 1'b1);
    sp(14'h64, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h2);
    apb(1'b1, LIN_LEVEL_OFS, 32'h32);
    sp(14'h31, 1'b1);
    sp(14'h32, 1'b0);
    apb(1'b1, LIN_LEVEL_OFS, 32'h2710);
    sp(14'h270F, 1'b1);
    sp(14'h2710, 1'b0);
    sp(14'h0, 1'b1);
  endtask

  task t_ready;
    apb(1'b1, CTRL_OFS, 32'h0);
    @(posedge pclk) din.main_power_on <= 1'b0;
    wt;
    chk("ready_power", 32'h0, {31'h0, sr});
    @(posedge pclk) din.main_power_on <= 1'b1;
    din.hw_base_block <= 1'b1;
    wt;
    chk("ready_block", 32'h0, {31'h0, sr});
    @(posedge pclk) din.hw_base_block <= 1'b0;
    wt;
    chk("ready_ok", 32'h1, {31'h0, sr});
    apb(1'b1, CTRL_OFS, 32'h4);
    wt;
    chk("abs_no_req", 32'h0, {31'h0, sr});
    @(posedge pclk) want_abs <= 1'b1;
    wt;
    wt;
    chk("abs_pending", 32'h0, {31'h0, sr});
    @(posedge pclk) din.abs_transfer_done <= 1'b1;
    wt;
    chk("abs_done", 32'h1, {31'h0, sr});
  endtask

  task t_pol;
    apb(1'b1, CTRL_OFS, 32'h8);
    wt;
    chk("pol_first", 32'h1, {31'h0, sr});
    @(posedge pclk) din.servo_on <= 1'b1;
    wt;
    chk("pol_start", 32'h1, {31'h0, ps});
    wt;
    chk("pol_wait", 32'h0, {31'h0, sr});
    @(posedge pclk) din.polarity_done <= 1'b1;
    wt;
    chk("pol_done", 32'h1, {31'h0, sr});
  endtask

  task t_pins;
    @(posedge pclk) din.warning_active <= 1'b1;
    wt;
    chk("warn_unallocated", 32'h4, {26'h0, pins});
    apb(1'b1, ALLOC_B_OFS, 32'h2);
    wt;
    wt;
    chk("pin_or", 32'h6, {26'h0, pins});
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", 32'h168, rd);
    apb(1'b1, STATUS_OFS, 32'h0);
    chk("status_ro", 32'h1, {31'h0, er});
  endtask

  // a mid-run reset is a restart: the running select goes back to alarms only
  task t_restart;
    @(posedge pclk) din.warning_code <= 3'h5;
    wt;
    chk("warn_shown", 32'h5, {29'h0, code});
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wt;
    chk("reset_sel", 32'h0, {29'h0, code});
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 5000) begin
        fails++;
        wrap_up;
      end
    end
  end

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = '0;
    pwdata   = '0;
    want_abs = 1'b0;
    din      = '0;
    din.main_power_on = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_codes;
    t_motion;
    t_ready;
    t_pol;
    t_pins;
    t_restart;
    wrap_up;
  end
endmodule
